// >>> shared/fwsr_pkg.sv
// constants for the flash status-polling host controller
package fwsr_pkg;
  localparam int CLK_MHZ = 100;
  // bus timing in ns, turned into whole cycles rounded up
  localparam int T_WRITE_LOW_NS  = 50;
  localparam int T_WRITE_HIGH_NS = 30;
  localparam int T_READ_LOW_NS   = 100;
  localparam int T_READ_GAP_NS   = 30;
  localparam int T_WRITE_LOW_CYC  = (T_WRITE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int T_WRITE_HIGH_CYC = (T_WRITE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int T_READ_LOW_CYC   = (T_READ_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int T_READ_GAP_CYC   = (T_READ_GAP_NS * CLK_MHZ + 999) / 1000;
  // register byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_ADDR   = 5'h04;
  localparam logic [4:0] OFS_WDATA  = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_RDATA  = 5'h10;
  // control bits
  localparam int CTRL_WRITE = 0;
  localparam int CTRL_READ  = 1;
  localparam int CTRL_POLL  = 2;
  localparam int CTRL_ABORT = 3;
  // status bits
  localparam int ST_BUSY    = 0;
  localparam int ST_OK      = 1;
  localparam int ST_FAIL    = 2;
  localparam int ST_READY   = 3;
  localparam int ST_TOG_A   = 4;
  localparam int ST_TOG_B   = 5;
  localparam int ST_WINDOW  = 6;
  localparam int ST_TIMEOUT = 7;
  // status bit positions on the data pins
  localparam int DQ_TOG_B   = 2;
  localparam int DQ_WINDOW  = 3;
  localparam int DQ_TIMEOUT = 5;
  localparam int DQ_TOG_A   = 6;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [19:0] RST_ADDR = 20'h00000;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  typedef enum logic [2:0] {
    FS_IDLE    = 3'b000,
    FS_WR_LOW  = 3'b001,
    FS_WR_HIGH = 3'b010,
    FS_RD_LOW  = 3'b011,
    FS_RD_GAP  = 3'b100,
    FS_EVAL    = 3'b101
  } fwsr_state_type;
  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ  = 2'b01,
    OP_POLL  = 2'b10,
    OP_RESET = 2'b11
  } fwsr_op_type;
endpackage

// >>> core/fwsr_host.sv
// host controller: drives flash strobes and runs the toggle-bit poll
`timescale 1ns/10ps
module fwsr_host
  import fwsr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [19:0] flash_addr_o,
  output logic      [7:0]  data_pins_o,
  output logic             data_pins_oe_o,
  input  wire logic [7:0]  data_pins_i,
  output logic             select_n_o,
  output logic             output_strobe_n_o,
  output logic             write_strobe_n_o,
  input  wire logic        ready_busy_n_in_i
);
  fwsr_state_type state_r, state_nxt;
  fwsr_op_type    op_r, op_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic [19:0] addr_r, addr_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic [7:0]  prev_r, prev_nxt;
  logic        second_r, second_nxt;
  logic        recheck_r, recheck_nxt;
  logic        ok_r, ok_nxt;
  logic        fail_r, fail_nxt;
  logic        tog_a_r, tog_a_nxt;
  logic        tog_b_r, tog_b_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [2:0]  ry_s_r, ry_s_nxt;
  logic        ready_r, ready_nxt;
  logic [7:0]  d1_r, d2_r, d3_r;
  logic        sel_n_r, sel_n_nxt;
  logic        oe_n_r, oe_n_nxt;
  logic        we_n_r, we_n_nxt;
  logic        doe_r, doe_nxt;
  logic        req, wr_req;
  logic [7:0]  ctrl_b;

  function automatic logic [7:0] cyc8(input int n);
    cyc8 = 8'(n - 1);
  endfunction

  assign req    = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_req = req & wb_we_i & wb_sel_i[0];
  assign ctrl_b = wb_dat_i[7:0];

  always_comb begin
    state_nxt   = state_r;
    op_nxt      = op_r;
    cnt_nxt     = cnt_r;
    addr_nxt    = addr_r;
    wdata_nxt   = wdata_r;
    rdata_nxt   = rdata_r;
    prev_nxt    = prev_r;
    second_nxt  = second_r;
    recheck_nxt = recheck_r;
    ok_nxt      = ok_r;
    fail_nxt    = fail_r;
    tog_a_nxt   = tog_a_r;
    tog_b_nxt   = tog_b_r;
    sel_n_nxt   = sel_n_r;
    oe_n_nxt    = oe_n_r;
    we_n_nxt    = we_n_r;
    doe_nxt     = doe_r;
    ack_nxt     = req;
    dat_nxt     = 32'h00000000;
    // only the agreeing later stages decide the level
    ry_s_nxt    = {ry_s_r[1:0], ready_busy_n_in_i};
    ready_nxt   = (ry_s_r[2] == ry_s_r[1]) ? ry_s_r[2] : ready_r;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        OFS_CTRL:   dat_nxt = 32'h00000000;
        OFS_ADDR:   dat_nxt = {12'h000, addr_r};
        OFS_WDATA:  dat_nxt = {24'h000000, wdata_r};
        OFS_STATUS: dat_nxt = {24'h000000, rdata_r[DQ_TIMEOUT],
                               rdata_r[DQ_WINDOW], tog_b_r, tog_a_r,
                               ready_r, fail_r, ok_r,
                               state_r != FS_IDLE};
        OFS_RDATA:  dat_nxt = {24'h000000, rdata_r};
        default:    dat_nxt = 32'h00000000;
      endcase
    end
    if (wr_req && state_r == FS_IDLE) begin
      if (wb_adr_i == OFS_ADDR) begin
        addr_nxt = wb_dat_i[19:0];
      end
      if (wb_adr_i == OFS_WDATA) begin
        wdata_nxt = wb_dat_i[7:0];
      end
    end
    case (state_r)
      FS_IDLE: begin
        if (wr_req && wb_adr_i == OFS_CTRL) begin
          if (ctrl_b[CTRL_WRITE]) begin
            op_nxt    = OP_WRITE;
            state_nxt = FS_WR_LOW;
          end else if (ctrl_b[CTRL_READ]) begin
            op_nxt    = OP_READ;
            state_nxt = FS_RD_LOW;
          end else if (ctrl_b[CTRL_POLL]) begin
            op_nxt      = OP_POLL;
            state_nxt   = FS_RD_LOW;
            second_nxt  = 1'b0;
            recheck_nxt = 1'b0;
            ok_nxt      = 1'b0;
            fail_nxt    = 1'b0;
            tog_a_nxt   = 1'b0;
            tog_b_nxt   = 1'b0;
          end
          if (ctrl_b[CTRL_WRITE]) begin
            sel_n_nxt = 1'b0;
            we_n_nxt  = 1'b0;
            doe_nxt   = 1'b1;
            cnt_nxt   = cyc8(T_WRITE_LOW_CYC);
          end else if (ctrl_b[CTRL_READ] || ctrl_b[CTRL_POLL]) begin
            sel_n_nxt = 1'b0;
            oe_n_nxt  = 1'b0;
            cnt_nxt   = cyc8(T_READ_LOW_CYC);
          end
        end
      end
      FS_WR_LOW: begin
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          // status becomes valid from this rising edge
          we_n_nxt  = 1'b1;
          sel_n_nxt = 1'b1;
          cnt_nxt   = cyc8(T_WRITE_HIGH_CYC);
          state_nxt = FS_WR_HIGH;
        end
      end
      FS_WR_HIGH: begin
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          doe_nxt   = 1'b0;
          state_nxt = FS_IDLE;
        end
      end
      FS_RD_LOW: begin
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else if (d2_r == d3_r) begin
          // the strobe edge ends the read cycle and flips the toggles
          rdata_nxt = d3_r;
          oe_n_nxt  = 1'b1;
          sel_n_nxt = 1'b1;
          cnt_nxt   = cyc8(T_READ_GAP_CYC);
          state_nxt = FS_RD_GAP;
        end
      end
      FS_RD_GAP: begin
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else if (op_r != OP_POLL) begin
          state_nxt = FS_IDLE;
        end else if (!second_r) begin
          prev_nxt   = rdata_r;
          second_nxt = 1'b1;
          sel_n_nxt  = 1'b0;
          oe_n_nxt   = 1'b0;
          cnt_nxt    = cyc8(T_READ_LOW_CYC);
          state_nxt  = FS_RD_LOW;
        end else begin
          state_nxt = FS_EVAL;
        end
      end
      FS_EVAL: begin
        second_nxt = 1'b0;
        tog_a_nxt  = prev_r[DQ_TOG_A] != rdata_r[DQ_TOG_A];
        tog_b_nxt  = prev_r[DQ_TOG_B] != rdata_r[DQ_TOG_B];
        if (prev_r[DQ_TOG_A] == rdata_r[DQ_TOG_A]) begin
          ok_nxt    = 1'b1;
          state_nxt = FS_IDLE;
        end else if (recheck_r) begin
          // still toggling after timeout: give up and reset the part
          fail_nxt  = 1'b1;
          op_nxt    = OP_RESET;
          wdata_nxt = CMD_RESET;
          sel_n_nxt = 1'b0;
          we_n_nxt  = 1'b0;
          doe_nxt   = 1'b1;
          cnt_nxt   = cyc8(T_WRITE_LOW_CYC);
          state_nxt = FS_WR_LOW;
        end else begin
          recheck_nxt = rdata_r[DQ_TIMEOUT];
          sel_n_nxt   = 1'b0;
          oe_n_nxt    = 1'b0;
          cnt_nxt     = cyc8(T_READ_LOW_CYC);
          state_nxt   = FS_RD_LOW;
        end
      end
      default: begin
        state_nxt = FS_IDLE;
      end
    endcase
    // abort leaves the poll between reads; strobes are not cut short
    // a failing poll still issues its reset write; an abort in that cycle is dropped
    if (wr_req && wb_adr_i == OFS_CTRL && ctrl_b[CTRL_ABORT] && we_n_nxt &&
        op_r == OP_POLL && (state_r == FS_RD_GAP || state_r == FS_EVAL)) begin
      state_nxt  = FS_IDLE;
      second_nxt = 1'b0;
      // a read just being started must not leave its strobes low in idle
      sel_n_nxt  = 1'b1;
      oe_n_nxt   = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    d1_r <= data_pins_i;
    d2_r <= d1_r;
    d3_r <= d2_r;
    if (rst_i) begin
      state_r   <= FS_IDLE;
      op_r      <= OP_WRITE;
      cnt_r     <= 8'h00;
      addr_r    <= RST_ADDR;
      wdata_r   <= RST_BYTE;
      rdata_r   <= RST_BYTE;
      prev_r    <= RST_BYTE;
      second_r  <= 1'b0;
      recheck_r <= 1'b0;
      ok_r      <= 1'b0;
      fail_r    <= 1'b0;
      tog_a_r   <= 1'b0;
      tog_b_r   <= 1'b0;
      ack_r     <= 1'b0;
      dat_r     <= 32'h00000000;
      ry_s_r    <= 3'h7;
      ready_r   <= 1'b1;
      sel_n_r   <= 1'b1;
      oe_n_r    <= 1'b1;
      we_n_r    <= 1'b1;
      doe_r     <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      op_r      <= op_nxt;
      cnt_r     <= cnt_nxt;
      addr_r    <= addr_nxt;
      wdata_r   <= wdata_nxt;
      rdata_r   <= rdata_nxt;
      prev_r    <= prev_nxt;
      second_r  <= second_nxt;
      recheck_r <= recheck_nxt;
      ok_r      <= ok_nxt;
      fail_r    <= fail_nxt;
      tog_a_r   <= tog_a_nxt;
      tog_b_r   <= tog_b_nxt;
      ack_r     <= ack_nxt;
      dat_r     <= dat_nxt;
      ry_s_r    <= ry_s_nxt;
      ready_r   <= ready_nxt;
      sel_n_r   <= sel_n_nxt;
      oe_n_r    <= oe_n_nxt;
      we_n_r    <= we_n_nxt;
      doe_r     <= doe_nxt;
    end
  end

  assign wb_dat_o          = dat_r;
  assign wb_ack_o          = ack_r;
  assign flash_addr_o      = addr_r;
  assign data_pins_o       = wdata_r;
  assign data_pins_oe_o    = doe_r;
  assign select_n_o        = sel_n_r;
  assign output_strobe_n_o = oe_n_r;
  assign write_strobe_n_o  = we_n_r;
endmodule

// >>> testbench/fwsr_host_sva.sv
// assertions on the host controller ports
`timescale 1ns/10ps
module fwsr_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        select_n_o,
  input wire logic        output_strobe_n_o,
  input wire logic        write_strobe_n_o,
  input wire logic        data_pins_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
  dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("stray read data");
  strobes_apart_a: assert property (
    write_strobe_n_o || output_strobe_n_o) else $error("both strobes");
  write_len_a: assert property ($fell(write_strobe_n_o) |->
    (!write_strobe_n_o)[*5] ##1 write_strobe_n_o) else $error("write width");
  write_drive_a: assert property (!write_strobe_n_o |->
    !select_n_o && data_pins_oe_o) else $error("write not driven");
  read_len_a: assert property ($fell(output_strobe_n_o) |->
    (!output_strobe_n_o)[*8] ##1 (!output_strobe_n_o)[*2])
    else $error("read too short");
  read_end_a: assert property ($rose(output_strobe_n_o) |->
    $rose(select_n_o)) else $error("select not released");
  read_gap_a: assert property ($rose(output_strobe_n_o) |->
    output_strobe_n_o[*3]) else $error("reads too close");
  read_float_a: assert property (!output_strobe_n_o |->
    !data_pins_oe_o) else $error("pins driven in read");
  read_bound_a: assert property ($fell(output_strobe_n_o) |->
    ##[10:40] $rose(output_strobe_n_o)) else $error("read never ends");
endmodule
bind fwsr_host fwsr_sva i_sva (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .select_n_o(select_n_o),
  .output_strobe_n_o(output_strobe_n_o),
  .write_strobe_n_o(write_strobe_n_o), .data_pins_oe_o(data_pins_oe_o));

// >>> testbench/fwsr_flash.sv
// behavioural flash device: status bits and ready/busy
`timescale 1ns/10ps
module fwsr_flash (
  input  wire logic [7:0] wd_i,
  input  wire logic       wd_oe_i,
  input  wire logic       select_n_i,
  input  wire logic       output_strobe_n_i,
  input  wire logic       write_strobe_n_i,
  output logic      [7:0] bus_o,
  output logic            busy_pull_o
);
  int         left = 0, arm_n = 0, reads = 0;
  logic       arm_er = 1'b0, arm_fl = 1'b0, erase = 1'b0, fail = 1'b0;
  logic       tog_a = 1'b0, tog_b = 1'b0;
  logic [7:0] last_byte = 8'h00;
  wire        rd_w = !select_n_i && !output_strobe_n_i;
  wire        wr_w = !select_n_i && !write_strobe_n_i;
  // next write starts an operation lasting n reads; with fl only an F0 write ends it
  task automatic arm(input int n, input logic er, input logic fl);
    arm_n = n;
    arm_er = er;
    arm_fl = fl;
  endtask
  assign busy_pull_o = (left != 0);
  always @(negedge wr_w) begin
    last_byte = wd_i;
    if (wd_i == 8'hF0)
      left = 0;
    else begin
      left = arm_n;
      erase = arm_er;
      fail = arm_fl;
    end
  end
  // a read ends at the first strobe release
  always @(negedge rd_w) begin
    reads++;
    if (left != 0) begin
      tog_a = ~tog_a;
      tog_b = tog_b ^ erase;
      if (!fail) left--;
    end
  end
  // released bus shows the inverse, never the held byte
  always_comb begin
    if (rd_w && left != 0)
      bus_o = {~last_byte[7] & ~erase, tog_a, fail, last_byte[4],
               erase, tog_b, last_byte[1:0]};
    else if (rd_w || !wd_oe_i)
      bus_o = rd_w ? last_byte : ~last_byte;
    else
      bus_o = wd_i;
  end
endmodule

// >>> testbench/fwsr_host_bench.sv
// self-checking bench for the flash status-polling host
`timescale 1ns/10ps
module fwsr_host_bench;
  import fwsr_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, busy;
  logic        data_pins_oe_o, select_n_o, output_strobe_n_o, write_strobe_n_o;
  logic [4:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [19:0] flash_addr_o;
  logic [7:0]  data_pins_o, bus;
  int          err_count = 0, total_checks = 0, cycles = 0;
  // ready/busy wire has a pull-up: released reads high
  fwsr_host i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .flash_addr_o(flash_addr_o),
    .data_pins_o(data_pins_o), .data_pins_oe_o(data_pins_oe_o),
    .data_pins_i(bus), .select_n_o(select_n_o),
    .output_strobe_n_o(output_strobe_n_o),
    .write_strobe_n_o(write_strobe_n_o),
    .ready_busy_n_in_i(busy ? 1'b0 : 1'b1));
  fwsr_flash i_flash (.wd_i(data_pins_o), .wd_oe_i(data_pins_oe_o),
    .select_n_i(select_n_o), .output_strobe_n_i(output_strobe_n_o),
    .write_strobe_n_i(write_strobe_n_o), .bus_o(bus), .busy_pull_o(busy));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic wb(input logic we, input logic [4:0] a, input int d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic run(input int c);
    wb(1'b1, OFS_CTRL, c);
    do wb(1'b0, OFS_STATUS, 0); while (rd[ST_BUSY] !== 1'b0);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic t_program();
    i_flash.arm(3, 1'b0, 1'b0);
    wb(1'b1, OFS_ADDR, 32'h12345);
    wb(1'b1, OFS_WDATA, 32'h5A);
    run(1);
    chk(i_flash.last_byte, 32'h5A, "byte");
    chk(flash_addr_o, 32'h12345, "addr");
    wb(1'b0, OFS_STATUS, 0);
    chk(rd & 32'h8, 32'h0, "ready while busy");
    i_flash.reads = 0;
    run(4);
    chk(rd, 32'h4A, "poll ok status");
    chk(i_flash.reads, 32'h6, "poll reads");
    $display("program test done");
  endtask
  task automatic t_fail();
    i_flash.arm(1000, 1'b1, 1'b1);
    wb(1'b1, OFS_WDATA, 32'h30);
    run(1);
    i_flash.reads = 0;
    run(4);
    chk(rd & 32'hF7, 32'hF4, "fail status");
    chk(i_flash.reads, 32'h4, "reads to fail");
    chk(i_flash.last_byte, 32'hF0, "reset command");
    chk(i_flash.left, 32'h0, "back to array");
    $display("fail test done");
  endtask
  task automatic t_abort();
    wb(1'b0, 5'h14, 0);
    chk(rd, 32'h0, "unmapped");
    i_flash.arm(1000, 1'b0, 1'b0);
    wb(1'b1, OFS_WDATA, 32'hC3);
    run(1);
    wb(1'b1, OFS_CTRL, 4);
    repeat (30) @(posedge clk_i);
    do begin
      wb(1'b1, OFS_CTRL, 8);
      wb(1'b0, OFS_STATUS, 0);
    end while (rd[ST_BUSY] !== 1'b0);
    chk(rd & 32'h6, 32'h0, "aborted poll");
    chk({select_n_o, output_strobe_n_o, write_strobe_n_o}, 32'h7,
        "strobes idle after abort");
    i_flash.left = 0;
    i_flash.reads = 0;
    run(4);
    chk(i_flash.reads, 32'h2, "restart reads");
    run(2);
    wb(1'b0, OFS_RDATA, 0);
    chk(rd, 32'hC3, "array byte");
    $display("abort test done");
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 5'h00;
    wb_dat_i = 32'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OFS_STATUS, 0);
    chk(rd, 32'h08, "status after reset");
    t_program();
    t_fail();
    t_abort();
    complete_run();
  end
endmodule
